/* File: core/fcs_pkg.sv */
package fcs_pkg;
  // timing
  localparam int CLK_NS = 50;
  localparam int TENTH_NS = 100_000_000;
  localparam int TENTH_CYC = TENTH_NS / CLK_NS;
  // register byte offsets
  localparam logic [7:0] A_NODE = 8'h00;
  localparam logic [7:0] A_CAN = 8'h04;
  localparam logic [7:0] A_SER = 8'h08;
  localparam logic [7:0] A_FMT = 8'h0c;
  localparam logic [7:0] A_TMO = 8'h10;
  localparam logic [7:0] A_REACT = 8'h14;
  localparam logic [7:0] A_RAMP = 8'h18;
  localparam logic [7:0] A_W4SEL = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_MASK = 8'h24;
  localparam logic [7:0] A_ACCEL = 8'h28;
  localparam logic [7:0] A_DECEL = 8'h2c;
  localparam logic [7:0] A_LIVE = 8'h30;
  localparam logic [7:0] A_TRIPCLR = 8'h34;
  // limits and defaults
  localparam logic [5:0] NODE_MAX = 6'h3f;
  localparam logic [5:0] NODE_DEF = 6'h01;
  localparam logic [9:0] CAN_MIN = 10'h07d;
  localparam logic [9:0] CAN_MAX = 10'h3e8;
  localparam logic [9:0] CAN_DEF = 10'h1f4;
  localparam logic [10:0] SER_MIN = 11'h060;
  localparam logic [10:0] SER_MAX = 11'h480;
  localparam logic [10:0] SER_DEF = 11'h480;
  localparam logic [1:0] FMT_N2 = 2'h0;
  localparam logic [1:0] FMT_O1 = 2'h1;
  localparam logic [1:0] FMT_E1 = 2'h2;
  localparam logic [5:0] TMO_MAX = 6'h32;
  localparam logic [5:0] TMO_DEF = 6'h14;
  localparam logic [1:0] RX_TRIP = 2'h0;
  localparam logic [1:0] RX_RAMP_TRIP = 2'h1;
  localparam logic [1:0] RX_RAMP = 2'h2;
  localparam logic [1:0] RX_PRESET = 2'h3;
  localparam logic [2:0] W4_TORQUE = 3'h0;
  localparam logic [2:0] W4_POWER = 3'h1;
  localparam logic [2:0] W4_DIN = 3'h2;
  localparam logic [2:0] W4_AIN2 = 3'h3;
  localparam logic [2:0] W4_HEAT = 3'h4;
  localparam logic [15:0] RAMP_DEF = 16'h0032;
  // status bits
  localparam int SB_LOSS = 0;
  localparam int SB_TRIP = 1;
  localparam int SB_BACK = 2;
  localparam int NSTAT = 3;
  localparam int NDIN = 8;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;
  typedef enum logic [3:0] {
    ST_OK = 4'b0001,
    ST_RAMP = 4'b0010,
    ST_TRIP = 4'b0100,
    ST_PRESET = 4'b1000
  } fcs_state_e;
endpackage

/* File: core/fcs_supervisor.sv */
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - node address register holds 0..63, resets to 1
// - CAN bit rate selectable 125..1000 kbps, default 500
// - serial bit rate 9.6..115.2 kbps, default 115.2, master matches
// - frame format: none/2 stop, odd/1 stop, even/1 stop
// - loss timeout 0.0..5.0 s, default 2.0, zero disables supervision
// - no valid telegram within timeout declares loss, applies reaction
// - code 0 trips and coasts; code 1 ramps to standstill then trips
// - code 2 ramps to standstill without trip; code 0 is default
// - code 3 keeps running at preset speed eight
// - ramp select 1 takes accel and decel from the fieldbus
// - ramp select 0, default, uses internal accel and decel times
// - output word 4 sent each cyclic exchange, selector 0..4, default 0
// - selector 0 gives torque, 0..2000 for 0..200.0 percent
// - selector 1 gives power in kW with two implied decimals
// - selector 2 gives digital input bit map, bit 0 is input 1
// - selector 3 gives analog input 2, 0..1000 for 0..100.0 percent
// - selector 4 gives heatsink temperature as scaled integer
module fcs_supervisor #(
  parameter int TENTH_CYC = fcs_pkg::TENTH_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fieldbus receiver side
  input wire logic telegram_ok,
  input wire logic exchange_stb,
  input wire logic [15:0] bus_accel,
  input wire logic [15:0] bus_decel,
  // drive measurements
  input wire logic motor_standstill,
  input wire logic [15:0] torque_val,
  input wire logic [15:0] power_val,
  input wire logic [fcs_pkg::NDIN-1:0] din_pin,
  input wire logic [15:0] ain2_val,
  input wire logic [15:0] heatsink_val,
  // settings to the link layers
  output logic [5:0] node_address_setting,
  output logic [9:0] can_bit_rate_setting,
  output logic [10:0] serial_bit_rate_setting,
  output logic [1:0] serial_frame_format,
  // drive control
  output logic trip_q,
  output logic coast_q,
  output logic ramp_stop_q,
  output logic preset8_run_q,
  output logic [15:0] accel_time_q,
  output logic [15:0] decel_time_q,
  // process data out
  output logic [15:0] pd_word4_q,
  output logic pd_word4_valid_q,
  // interrupt
  output logic irq_q
);
  import fcs_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [NDIN-1:0] din_m_q, din_s_q;
  logic [5:0] node_q, tmo_q;
  logic [9:0] can_q;
  logic [10:0] ser_q;
  logic [1:0] fmt_q, react_q;
  logic ramp_sel_q;
  logic [2:0] w4sel_q;
  logic [15:0] accel_q, decel_q;
  logic [NSTAT-1:0] stat_q, mask_q, ev;
  logic [31:0] sub_q;
  logic [5:0] tenth_q;
  logic loss_fire, tmo_wr;
  fcs_state_e st_q, st_d;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, wmask_q, wv;
  logic wr_do, rd_do, wr_hit, rd_hit, rd_stat;
  logic [31:0] rd_d;
  logic [15:0] w4_d;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // input pins are asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      din_m_q <= din_pin;
      din_s_q <= din_m_q;
    end
  end

  // axi write channel: address and data taken in either order
  assign wr_do = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wv = wdata_q & wmask_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wmask_q <= 32'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        for (int i = 0; i < 4; i++) begin
          wmask_q[i*8 +: 8] <= {8{s_axi_wstrb[i]}};
        end
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OK : RESP_SLV;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    case (awaddr_q)
      A_NODE, A_CAN, A_SER, A_FMT, A_TMO, A_REACT, A_RAMP, A_W4SEL,
      A_STAT, A_MASK, A_ACCEL, A_DECEL, A_LIVE, A_TRIPCLR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // settings; out-of-range writes are dropped so the field stays legal, except mask, accel and decel, which take the low bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      node_q <= NODE_DEF;
      can_q <= CAN_DEF;
      ser_q <= SER_DEF;
      fmt_q <= FMT_N2;
      tmo_q <= TMO_DEF;
      react_q <= RX_TRIP;
      ramp_sel_q <= 1'b0;
      w4sel_q <= W4_TORQUE;
      mask_q <= '0;
      accel_q <= RAMP_DEF;
      decel_q <= RAMP_DEF;
    end else if (wr_do) begin
      case (awaddr_q)
        A_NODE: begin
          if (wv[31:6] == '0) node_q <= wv[5:0];
        end
        A_CAN: begin
          if (wv[31:10] == '0 && wv[9:0] >= CAN_MIN && wv[9:0] <= CAN_MAX)
            can_q <= wv[9:0];
        end
        A_SER: begin
          if (wv[31:11] == '0 && wv[10:0] >= SER_MIN && wv[10:0] <= SER_MAX)
            ser_q <= wv[10:0];
        end
        A_FMT: begin
          if (wv[31:2] == '0 && wv[1:0] <= FMT_E1) fmt_q <= wv[1:0];
        end
        A_TMO: begin
          if (wv[31:6] == '0 && wv[5:0] <= TMO_MAX) tmo_q <= wv[5:0];
        end
        A_REACT: begin
          if (wv[31:2] == '0) react_q <= wv[1:0];
        end
        A_RAMP: begin
          if (wv[31:1] == '0) ramp_sel_q <= wv[0];
        end
        A_W4SEL: begin
          if (wv[31:3] == '0 && wv[2:0] <= W4_HEAT) w4sel_q <= wv[2:0];
        end
        A_MASK: mask_q <= wv[NSTAT-1:0];
        A_ACCEL: accel_q <= (accel_q & ~wmask_q[15:0]) | wv[15:0];
        A_DECEL: decel_q <= (decel_q & ~wmask_q[15:0]) | wv[15:0];
        default: ;
      endcase
    end
  end

  // loss timer counts whole tenths of a second since the last telegram
  // a new timeout restarts the count, so a shorter one is never overrun
  assign tmo_wr = wr_do && awaddr_q == A_TMO;
  assign loss_fire = (tmo_q != '0) && (tenth_q == tmo_q) && !telegram_ok
                     && (st_q == ST_OK);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sub_q <= 32'h0;
      tenth_q <= 6'h0;
    end else if (telegram_ok || tmo_q == '0 || st_q != ST_OK || tmo_wr) begin
      sub_q <= 32'h0;
      tenth_q <= 6'h0;
    end else if (tenth_q != tmo_q) begin
      if (sub_q == 32'(TENTH_CYC - 1)) begin
        sub_q <= 32'h0;
        tenth_q <= tenth_q + 6'h1;
      end else begin
        sub_q <= sub_q + 32'h1;
      end
    end
  end

  // loss reaction; ramp-only and preset recover on the next telegram
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OK: begin
        if (loss_fire) begin
          case (react_q)
            RX_TRIP: st_d = ST_TRIP;
            RX_RAMP_TRIP, RX_RAMP: st_d = ST_RAMP;
            default: st_d = ST_PRESET;
          endcase
        end
      end
      ST_RAMP: begin
        if (telegram_ok && react_q == RX_RAMP) st_d = ST_OK;
        else if (motor_standstill && react_q == RX_RAMP_TRIP)
          st_d = ST_TRIP;
      end
      ST_PRESET: begin
        if (telegram_ok) st_d = ST_OK;
      end
      ST_TRIP: begin
        if (wr_do && awaddr_q == A_TRIPCLR) st_d = ST_OK;
      end
      default: st_d = ST_OK;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_OK;
      trip_q <= 1'b0;
      coast_q <= 1'b0;
      ramp_stop_q <= 1'b0;
      preset8_run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      trip_q <= st_d == ST_TRIP;
      // coast only on an immediate trip; ramp-then-trip is already stopped
      coast_q <= (st_d == ST_TRIP) && (react_q == RX_TRIP);
      ramp_stop_q <= st_d == ST_RAMP;
      preset8_run_q <= st_d == ST_PRESET;
    end
  end

  // ramp source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accel_time_q <= RAMP_DEF;
      decel_time_q <= RAMP_DEF;
    end else if (ramp_sel_q) begin
      accel_time_q <= bus_accel;
      decel_time_q <= bus_decel;
    end else begin
      accel_time_q <= accel_q;
      decel_time_q <= decel_q;
    end
  end

  // output word 4 source
  always_comb begin
    case (w4sel_q)
      W4_TORQUE: w4_d = torque_val;
      W4_POWER: w4_d = power_val;
      W4_DIN: w4_d = {{(16-NDIN){1'b0}}, din_s_q};
      W4_AIN2: w4_d = ain2_val;
      W4_HEAT: w4_d = heatsink_val;
      default: w4_d = 16'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_word4_q <= 16'h0;
      pd_word4_valid_q <= 1'b0;
    end else begin
      pd_word4_valid_q <= exchange_stb;
      if (exchange_stb) pd_word4_q <= w4_d;
    end
  end

  // events; a set in the cycle of the clearing read wins
  assign ev[SB_LOSS] = loss_fire;
  assign ev[SB_TRIP] = (st_d == ST_TRIP) && (st_q != ST_TRIP);
  assign ev[SB_BACK] = telegram_ok && (st_q == ST_RAMP || st_q == ST_PRESET);
  assign rd_stat = rd_do && s_axi_araddr == A_STAT;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (rd_stat ? '0 : stat_q) | ev;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // axi read channel
  assign rd_do = s_axi_arvalid && s_axi_arready;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      A_NODE: rd_d = {26'h0, node_q};
      A_CAN: rd_d = {22'h0, can_q};
      A_SER: rd_d = {21'h0, ser_q};
      A_FMT: rd_d = {30'h0, fmt_q};
      A_TMO: rd_d = {26'h0, tmo_q};
      A_REACT: rd_d = {30'h0, react_q};
      A_RAMP: rd_d = {31'h0, ramp_sel_q};
      A_W4SEL: rd_d = {29'h0, w4sel_q};
      A_STAT: rd_d = {{(32-NSTAT){1'b0}}, stat_q};
      A_MASK: rd_d = {{(32-NSTAT){1'b0}}, mask_q};
      A_ACCEL: rd_d = {16'h0, accel_q};
      A_DECEL: rd_d = {16'h0, decel_q};
      A_LIVE: rd_d = {28'h0, st_q};
      A_TRIPCLR: rd_d = 32'h0;
      default: begin
        rd_d = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OK;
    end else if (rd_do) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_hit ? RESP_OK : RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign node_address_setting = node_q;
  assign can_bit_rate_setting = can_q;
  assign serial_bit_rate_setting = ser_q;
  assign serial_frame_format = fmt_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [31:0] gap_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) gap_q <= 32'h0;
    else if (telegram_ok || tmo_q == '0 || st_q != ST_OK || tmo_wr)
      gap_q <= 32'h0;
    else gap_q <= gap_q + 32'h1;
  end

  sequence s_loss_ramp;
    loss_fire && react_q == RX_RAMP_TRIP;
  endsequence
  sequence s_stop_reached;
    ramp_stop_q && motor_standstill && react_q == RX_RAMP_TRIP;
  endsequence

  AST_NODE_RANGE: assert property (node_q <= NODE_MAX)
    else $error("node address out of range");
  AST_CAN_RANGE: assert property (can_q >= CAN_MIN && can_q <= CAN_MAX)
    else $error("can rate out of range");
  AST_SER_RANGE: assert property (ser_q >= SER_MIN && ser_q <= SER_MAX)
    else $error("serial rate out of range");
  AST_FMT_LEGAL: assert property (fmt_q != 2'h3)
    else $error("illegal frame format");
  AST_TMO_OFF: assert property (
    tmo_q == '0 && st_q == ST_OK |=> !trip_q && !ramp_stop_q && !preset8_run_q)
    else $error("loss with supervision off");
  AST_LOSS_GAP: assert property (
    loss_fire |-> gap_q == 32'(tmo_q) * 32'(TENTH_CYC))
    else $error("loss at wrong time");
  AST_RESTART: assert property (
    telegram_ok |=> sub_q == 32'h0 && tenth_q == 6'h0 && !loss_fire)
    else $error("telegram did not restart timer");
  AST_TRIP_COAST: assert property (
    loss_fire && react_q == RX_TRIP |=> trip_q && coast_q && !ramp_stop_q)
    else $error("code 0 did not trip and coast");
  AST_RAMP_FIRST: assert property (
    s_loss_ramp |=> ramp_stop_q && !trip_q)
    else $error("code 1 did not ramp first");
  AST_RAMP_THEN_TRIP: assert property (
    s_stop_reached |=> trip_q && !coast_q)
    else $error("code 1 did not trip at standstill");
  AST_RAMP_NO_TRIP: assert property (
    loss_fire && react_q == RX_RAMP |=> ramp_stop_q && !trip_q)
    else $error("code 2 wrong reaction");
  AST_PRESET: assert property (
    loss_fire && react_q == RX_PRESET |=> preset8_run_q && !trip_q)
    else $error("code 3 wrong reaction");
  AST_RAMP_BUS: assert property (
    ramp_sel_q |=> accel_time_q == $past(bus_accel))
    else $error("bus ramp not used");
  AST_RAMP_INT: assert property (
    !ramp_sel_q |=> decel_time_q == $past(decel_q))
    else $error("internal ramp not used");
  AST_W4_SENT: assert property (
    exchange_stb |=> pd_word4_valid_q && w4sel_q <= W4_HEAT)
    else $error("word 4 not sent");
  AST_W4_DIN: assert property (
    exchange_stb && w4sel_q == W4_DIN |=> pd_word4_q[NDIN-1:0] == $past(din_s_q))
    else $error("word 4 digital map wrong");
  AST_W4_TORQUE: assert property (
    exchange_stb && w4sel_q == W4_TORQUE |=> pd_word4_q == $past(torque_val))
    else $error("word 4 torque wrong");
endmodule

/* File: testbench/fcs_master_model.sv */
`timescale 1ns/1ps
module fcs_master_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bench control
  input wire logic run,
  input wire logic [7:0] period,
  input wire logic send,
  // device link settings
  input wire logic [10:0] ser_rate,
  input wire logic [1:0] ser_fmt,
  // telegram side
  output logic telegram_ok,
  output logic exchange_stb,
  output logic [15:0] bus_accel,
  output logic [15:0] bus_decel
);
  logic [7:0] gap_q;
  logic [10:0] rate_q;
  logic [1:0] fmt_q;
  logic fire;
  // every good telegram also carries one cyclic exchange
  // a master still framing at the old rate or format sends nothing valid
  assign fire = (send || (run && gap_q + 8'h01 >= period))
                && rate_q == ser_rate && fmt_q == ser_fmt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 8'h00;
      telegram_ok <= 1'b0;
      exchange_stb <= 1'b0;
      bus_accel <= 16'h0000;
      bus_decel <= 16'h0000;
    end else begin
      gap_q <= fire ? 8'h00 : gap_q + 8'h01;
      telegram_ok <= fire;
      exchange_stb <= fire;
      if (fire) begin
        bus_accel <= 16'($urandom);
        bus_decel <= 16'($urandom);
      end
    end
  end
  // master frames at the device's rate and format, or nothing is valid
  always_ff @(posedge clk_sys) begin
    rate_q <= ser_rate;
    fmt_q <= ser_fmt;
  end
endmodule

/* File: testbench/drive_fieldbus_comm_supervisor_tb_top.sv */
`timescale 1ns/1ps
module drive_fieldbus_comm_supervisor_tb_top;
  import fcs_pkg::*;
  localparam int TC = 4;
  logic clk_sys = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic telegram_ok, exchange_stb, motor_standstill = 1'b0;
  logic [15:0] bus_accel, bus_decel, torque_val = 16'h0, power_val = 16'h0;
  logic [15:0] ain2_val = 16'h0, heatsink_val = 16'h0;
  logic [NDIN-1:0] din_pin = '0;
  logic [5:0] node_address_setting;
  logic [9:0] can_bit_rate_setting;
  logic [10:0] serial_bit_rate_setting;
  logic [1:0] serial_frame_format;
  logic trip_q, coast_q, ramp_stop_q, preset8_run_q, pd_word4_valid_q, irq_q;
  logic [15:0] accel_time_q, decel_time_q, pd_word4_q;
  logic run = 1'b1, send = 1'b0;
  logic [7:0] period = 8'h14;
  logic [3:0] flags;
  logic [31:0] v, sh[8];
  int failures = 0, samples_checked = 0, seed_v, n;
  logic [7:0] ca[8] = '{A_NODE, A_CAN, A_SER, A_FMT, A_TMO, A_REACT, A_RAMP,
                        A_W4SEL};
  logic [31:0] cmin[8] = '{32'h0, CAN_MIN, SER_MIN, 32'h0, 32'h0, 32'h0,
                           32'h0, 32'h0};
  logic [31:0] cmax[8] = '{NODE_MAX, CAN_MAX, SER_MAX, FMT_E1, TMO_MAX,
                           RX_PRESET, 32'h1, W4_HEAT};
  logic [31:0] cdef[8] = '{NODE_DEF, CAN_DEF, SER_DEF, FMT_N2, TMO_DEF,
                           RX_TRIP, 32'h0, W4_TORQUE};
  assign flags = {trip_q, coast_q, ramp_stop_q, preset8_run_q};

  fcs_supervisor #(.TENTH_CYC(TC)) fcs_supervisor_inst (
    .clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .telegram_ok, .exchange_stb, .bus_accel, .bus_decel, .motor_standstill,
    .torque_val, .power_val, .din_pin, .ain2_val, .heatsink_val,
    .node_address_setting, .can_bit_rate_setting, .serial_bit_rate_setting,
    .serial_frame_format, .trip_q, .coast_q, .ramp_stop_q, .preset8_run_q,
    .accel_time_q, .decel_time_q, .pd_word4_q, .pd_word4_valid_q, .irq_q
  );
  fcs_master_model fcs_master_model_inst (
    .clk_sys, .rst_b, .run, .period, .send,
    .ser_rate(serial_bit_rate_setting), .ser_fmt(serial_frame_format),
    .telegram_ok, .exchange_stb, .bus_accel, .bus_decel
  );

  always #25 clk_sys = ~clk_sys;

  task automatic stop_test();
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // handshakes are sampled before this edge's updates land
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int k;
    @(posedge clk_sys);
    k = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (k < 50) begin
      @(posedge clk_sys);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk(s_axi_bresp, er, "bresp");
        k = 99;
      end
    end
    s_axi_bready <= 1'b0;
    if (k != 99) chk(32'h1, 32'h0, "write hang");
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er, input logic ck);
    int k;
    @(posedge clk_sys);
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (k < 50) begin
      @(posedge clk_sys);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        if (ck) chk(s_axi_rdata, d, "rdata");
        chk(s_axi_rresp, er, "rresp");
        k = 99;
      end
    end
    s_axi_rready <= 1'b0;
    if (k != 99) chk(32'h1, 32'h0, "read hang");
  endtask

  task automatic tel();
    @(posedge clk_sys);
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
  endtask

  // out-of-range writes leave the old setting in place
  function automatic logic [31:0] nxt(input int i, input logic [31:0] o,
                                      input logic [31:0] w);
    return (w >= cmin[i] && w <= cmax[i]) ? w : o;
  endfunction

  function automatic logic [31:0] exp_w4(input logic [2:0] s);
    case (s)
      W4_TORQUE: return {16'h0, torque_val};
      W4_POWER: return {16'h0, power_val};
      W4_DIN: return {24'h0, din_pin};
      W4_AIN2: return {16'h0, ain2_val};
      default: return {16'h0, heatsink_val};
    endcase
  endfunction

  // {trip, coast, ramp stop, preset 8}
  function automatic logic [31:0] loss_exp(input logic [1:0] c,
                                           input logic still);
    case (c)
      RX_TRIP: return 32'hc;
      RX_RAMP_TRIP: return still ? 32'h8 : 32'h2;
      RX_RAMP: return 32'h2;
      default: return 32'h1;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    seed_v = $urandom(32'hd38af02a);
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      axi_rd(ca[i], cdef[i], RESP_OK, 1'b1);
      sh[i] = cdef[i];
    end
    axi_rd(A_ACCEL, RAMP_DEF, RESP_OK, 1'b1);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 8; k++) begin
        v = k == 0 ? cmax[i] + 32'h1 : k == 1 ? cmax[i] :
            k == 2 ? cmin[i] - 32'h1 : $urandom_range(0, 2 * cmax[i]);
        axi_wr(ca[i], v, RESP_OK);
        sh[i] = nxt(i, sh[i], v);
        axi_rd(ca[i], sh[i], RESP_OK, 1'b1);
      end
    end
    repeat (2) @(posedge clk_sys);
    chk(node_address_setting, sh[0], "node");
    chk(can_bit_rate_setting, sh[1], "can rate");
    chk(serial_bit_rate_setting, sh[2], "serial rate");
    chk(serial_frame_format, sh[3], "format");
    axi_wr(8'h3c, 32'h1, RESP_SLV);
    axi_rd(8'h3c, 32'h0, RESP_SLV, 1'b1);
    // settle: no supervision, any trip cleared, status emptied
    axi_wr(A_TMO, 32'h0, RESP_OK);
    axi_wr(A_REACT, 32'h2, RESP_OK);
    tel();
    axi_wr(A_TRIPCLR, 32'h1, RESP_OK);
    axi_rd(A_STAT, 32'h0, RESP_OK, 1'b0);
    run <= 1'b0;
    v = $urandom;
    axi_wr(A_RAMP, 32'h0, RESP_OK);
    axi_wr(A_ACCEL, v, RESP_OK);
    axi_wr(A_DECEL, ~v, RESP_OK);
    tel();
    repeat (3) @(posedge clk_sys);
    chk({accel_time_q, decel_time_q}, {v[15:0], ~v[15:0]}, "int");
    axi_wr(A_RAMP, 32'h1, RESP_OK);
    tel();
    repeat (3) @(posedge clk_sys);
    chk({accel_time_q, decel_time_q}, {bus_accel, bus_decel}, "bus");
    for (int s = 0; s < 5; s++) begin
      axi_wr(A_W4SEL, 32'(s), RESP_OK);
      torque_val <= 16'($urandom_range(0, 2000));
      power_val <= 16'($urandom);
      din_pin <= NDIN'($urandom);
      ain2_val <= 16'($urandom_range(0, 1000));
      heatsink_val <= 16'($urandom);
      repeat (4) @(posedge clk_sys);
      tel();
      n = 0;
      while (!pd_word4_valid_q && n < 10) begin
        @(posedge clk_sys);
        n++;
      end
      chk(pd_word4_valid_q, 32'h1, "w4 valid");
      chk(pd_word4_q, exp_w4(s[2:0]), "w4");
    end
    axi_wr(A_MASK, 32'h0, RESP_OK);
    period <= 8'h03;
    run <= 1'b1;
    axi_wr(A_TMO, 32'h1, RESP_OK);
    repeat (40) @(posedge clk_sys);
    chk(flags, 32'h0, "kept alive");
    for (int c = 0; c < 4; c++) begin
      axi_wr(A_REACT, 32'(c), RESP_OK);
      axi_rd(A_STAT, 32'h0, RESP_OK, 1'b0);
      run <= 1'b0;
      @(posedge clk_sys);
      chk(flags, 32'h0, "early loss");
      repeat (12) @(posedge clk_sys);
      chk(flags, loss_exp(c[1:0], 1'b0), "loss");
      axi_rd(A_LIVE, 32'(c == 0 ? ST_TRIP : c == 3 ? ST_PRESET : ST_RAMP),
             RESP_OK, 1'b1);
      motor_standstill <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(flags, loss_exp(c[1:0], 1'b1), "stopped");
      if (c == 0) begin
        chk(irq_q, 32'h0, "masked irq");
        axi_wr(A_MASK, 32'h7, RESP_OK);
        repeat (2) @(posedge clk_sys);
        chk(irq_q, 32'h1, "irq");
        axi_rd(A_STAT, 32'h3, RESP_OK, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk(irq_q, 32'h0, "irq clear");
        axi_wr(A_MASK, 32'h0, RESP_OK);
      end
      motor_standstill <= 1'b0;
      run <= 1'b1;
      axi_wr(A_TRIPCLR, 32'h1, RESP_OK);
      repeat (6) @(posedge clk_sys);
      chk(flags, 32'h0, "recover");
      axi_rd(A_STAT, c == 0 ? 32'h0 : c == 1 ? 32'h3 : 32'h5,
             RESP_OK, 1'b1);
    end
    axi_wr(A_TMO, 32'h0, RESP_OK);
    run <= 1'b0;
    repeat (60) @(posedge clk_sys);
    chk(flags, 32'h0, "disabled");
    stop_test();
  end
endmodule
